// ### sim/ftpc_checker.sv
`timescale 1ns/10ps
module ftpc_checker (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Watched ports
	input wire ftpc_pkg::ftpc_mode_e mode_i,
	input wire logic [3:0] unit_busy_i,
	input wire logic prog_erase_req_i,
	input wire ftpc_pkg::ftpc_pins_s pins_i,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe_o,
	input wire logic ready_busy_n_oe_o,
	input wire logic cycle_valid_o,
	input wire ftpc_pkg::ftpc_cycle_s cycle_o,
	input wire logic standby_o,
	input wire logic prog_erase_refused_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence wr_edge;
		!pins_i.ce_n && !pins_i.write_strobe_n ##1 !pins_i.ce_n && pins_i.write_strobe_n;
	endsequence
	AST_BUSY: assert property (ready_busy_n_oe_o == $past(|unit_busy_i)) else $error("rb");
	AST_STBY: assert property (pins_i.ce_n && unit_busy_i == 0 |=> standby_o) else $error("sb");
	AST_CMD: assert property (wr_edge ##0 pins_i.cle && !pins_i.ale && !mode_i[1]
		|-> ##3 cycle_valid_o && cycle_o.kind == 2'h0) else $error("cmd");
	AST_ADDR: assert property (wr_edge ##0 pins_i.ale && !pins_i.cle && !mode_i[1]
		|-> ##3 cycle_valid_o && cycle_o.kind == 2'h1) else $error("adr");
	AST_NODATA: assert property (wr_edge ##0 !pins_i.cle && !pins_i.ale && mode_i[2]
		|-> ##3 !cycle_valid_o) else $error("dat");
	AST_SEL: assert property (cycle_valid_o |-> !$past(pins_i.ce_n, 3)) else $error("sel");
	AST_WP: assert property (!pins_i.write_protect_n && prog_erase_req_i
		|=> prog_erase_refused_o) else $error("wp");
	AST_REL: assert property ((pins_i.ce_n && !mode_i[1]) [*3] |-> !dq_oe_o) else $error("oe");
	AST_POP: assert property ($changed(dq_o) |-> $past(pins_i.read_strobe_n, 4)
		&& !$past(pins_i.read_strobe_n, 3)) else $error("pop");
endmodule : ftpc_checker
bind ftpc_target ftpc_checker u_chk (.*);

// ### sim/ftpc_host_model.sv
`timescale 1ns/10ps
module ftpc_host_model (
	// Clock
	input wire logic ref_clk_i,
	// Target pins
	output ftpc_pkg::ftpc_pins_s pins_o,
	output logic [7:0] dq_o
);
	logic read_strobe_comp;
	assign read_strobe_comp = pins_o.ce_n ? 1'b1 : !pins_o.read_strobe_n;
	initial begin
		pins_o = 6'h27;
		dq_o = 8'h00;
	end
	task automatic cyc(input logic ce_n, input logic [1:0] k, input logic [7:0] d);
		@(posedge ref_clk_i);
		pins_o.ce_n <= ce_n;
		pins_o.cle <= k == 2'h0;
		pins_o.ale <= k == 2'h1;
		pins_o.write_strobe_n <= 1'b0;
		dq_o <= d;
		repeat (2) @(posedge ref_clk_i);
		pins_o.write_strobe_n <= 1'b1;
		// The target decodes the cycle three edges after the strobe rises, so the
		// cycle-type lines and the bus must still stand at the third edge.
		repeat (3) @(posedge ref_clk_i);
		pins_o.cle <= 1'b0;
		pins_o.ale <= 1'b0;
		// Released bus shows the inverse so stale data never passes for fresh.
		dq_o <= ~d;
	endtask : cyc
	task automatic rd();
		@(posedge ref_clk_i);
		pins_o.ce_n <= 1'b0;
		pins_o.read_strobe_n <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		pins_o.read_strobe_n <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
	endtask : rd
endmodule : ftpc_host_model

// ### sim/ftpc_target_bench.sv
`timescale 1ns/10ps
module ftpc_target_bench;
	logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, pe_req = 1'b0, rd_valid = 1'b0, wp_n = 1'b1;
	logic rd_ready, cyc_v, dq_oe, rb_oe, rb_n, stby, go, refused;
	logic [3:0] busy = 4'h0;
	logic [7:0] rd_data = 8'h00, host_dq, dq, d, exp_q[$];
	ftpc_pkg::ftpc_mode_e mode = ftpc_pkg::FTPC_SINGLE_RATE_MODE;
	ftpc_pkg::ftpc_pins_s hp;
	ftpc_pkg::ftpc_cycle_s cyc;
	int n_errors = 0, num_checks = 0, seed = 36, n_valid = 0, ticks = 0;
	wire rb_line = rb_oe ? rb_n : 1'b1;
	ftpc_host_model host (.ref_clk_i(ref_clk_i), .pins_o(hp), .dq_o(host_dq));
	ftpc_target dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .mode_i(mode),
		.unit_busy_i(busy), .prog_erase_req_i(pe_req), .pins_i({hp[5:1], wp_n}),
		.dq_i(dq_oe ? dq : host_dq), .dq_o(dq), .dq_oe_o(dq_oe), .dqs_o(), .dqs_oe_o(),
		.ready_busy_n_o(rb_n), .ready_busy_n_oe_o(rb_oe), .cycle_valid_o(cyc_v),
		.cycle_o(cyc), .rd_valid_i(rd_valid), .rd_ready_o(rd_ready), .rd_data_i(rd_data),
		.standby_o(stby), .prog_erase_go_o(go), .prog_erase_refused_o(refused));
	initial forever #25 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		n_valid <= n_valid + int'(cyc_v);
		ticks <= ticks + 1;
		if (ticks == 3000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	function automatic logic ok(input logic ce_n, input logic [1:0] k);
		return !ce_n && !mode[1] && !(mode[2] && k == 2'h2);
	endfunction : ok
	task automatic wr(input logic ce_n, input logic [1:0] k);
		int v0;
		v0 = n_valid;
		d = 8'($random(seed));
		host.cyc(ce_n, k, d);
		repeat (3) @(posedge ref_clk_i);
		#1;
		chk(16'(n_valid - v0), 16'(ok(ce_n, k)));
		if (ok(ce_n, k)) chk(16'(cyc), {6'h00, k, d});
	endtask : wr
	initial begin
		repeat (20) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk_i);
			mode <= ftpc_pkg::ftpc_mode_e'(3'h1 << i);
			for (int k = 0; k < 3; k++) wr(1'b0, 2'(k));
			wr(1'($random(seed)), 2'h0);
		end
		wr(1'b1, 2'h1);
		repeat (10) begin
			@(posedge ref_clk_i);
			busy <= 4'($random(seed));
			wp_n <= 1'($random(seed));
			pe_req <= 1'($random(seed));
			repeat (2) @(posedge ref_clk_i);
			#1;
			chk(16'(rb_line), 16'(busy == 0));
			chk(16'(stby), 16'(busy == 0));
			chk(16'({go, refused}), 16'({pe_req & wp_n, pe_req & !wp_n}));
		end
		@(posedge ref_clk_i);
		mode <= ftpc_pkg::FTPC_SINGLE_RATE_MODE;
		rd_valid <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			rd_data <= 8'($random(seed));
			#1;
			if (rd_ready) exp_q.push_back(rd_data);
			@(posedge ref_clk_i);
		end
		rd_valid <= 1'b0;
		chk(16'(exp_q.size()), 16'(ftpc_pkg::FTPC_FIFO_DEPTH));
		repeat (9) begin
			if (exp_q.size() > 0) d = exp_q.pop_front();
			host.rd();
			chk(16'(dq), 16'(d));
		end
		end_of_test();
	end
endmodule : ftpc_target_bench

// ### src/ftpc_fifo.sv
`timescale 1ns/10ps
module ftpc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             sys_rst_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	always_comb begin
		push = in_valid_i && (cnt_q != AW'(0) + (AW+1)'(DEPTH));
		pop  = (cnt_q != '0) && out_ready_i;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rd_q];
endmodule : ftpc_fifo

// ### src/ftpc_pkg.sv
package ftpc_pkg;

	// ------------------------------------------------------------
	// Interface modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FTPC_SINGLE_RATE_MODE     = 3'b001,
		FTPC_DOUBLE_RATE_MODE_ONE = 3'b010,
		FTPC_DOUBLE_RATE_MODE_TWO = 3'b100
	} ftpc_mode_e;

	// ------------------------------------------------------------
	// Widths, cycle kinds and reset values
	// ------------------------------------------------------------
	localparam int unsigned FTPC_DATA_W     = 8;
	localparam int unsigned FTPC_FIFO_DEPTH = 8;
	localparam logic [1:0]  FTPC_KIND_CMD   = 2'h0;
	localparam logic [1:0]  FTPC_KIND_ADDR  = 2'h1;
	localparam logic [1:0]  FTPC_KIND_DATA  = 2'h2;
	localparam logic [7:0]  FTPC_DATA_RST   = 8'h00;
	localparam logic [2:0]  FTPC_SYNC_RST   = 3'h7;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] kind;
		logic [7:0] data;
	} ftpc_cycle_s;

	typedef struct packed {
		logic       ce_n;
		logic       cle;
		logic       ale;
		logic       write_strobe_n;
		logic       read_strobe_n;
		logic       write_protect_n;
	} ftpc_pins_s;

endpackage : ftpc_pkg

// ### src/ftpc_target.sv
`timescale 1ns/10ps
module ftpc_target (
	// Clock and reset
	input  wire logic                ref_clk_i,
	input  wire logic                sys_rst_i,
	// Mode and internal status
	input  wire ftpc_pkg::ftpc_mode_e mode_i,
	input  wire logic [3:0]          unit_busy_i,
	input  wire logic                prog_erase_req_i,
	// Host pins
	input  wire ftpc_pkg::ftpc_pins_s pins_i,
	input  wire logic [7:0]          dq_i,
	output logic [7:0]               dq_o,
	output logic                     dq_oe_o,
	output logic                     dqs_o,
	output logic                     dqs_oe_o,
	output logic                     ready_busy_n_o,
	output logic                     ready_busy_n_oe_o,
	// Internal array side
	output logic                     cycle_valid_o,
	output ftpc_pkg::ftpc_cycle_s    cycle_o,
	input  wire logic                rd_valid_i,
	output logic                     rd_ready_o,
	input  wire logic [7:0]          rd_data_i,
	output logic                     standby_o,
	output logic                     prog_erase_go_o,
	output logic                     prog_erase_refused_o
);
	// ------------------------------------------------------------
	// Pin history for edge detection
	// ------------------------------------------------------------
	logic [2:0] we_q, we_d, re_q, re_d;
	logic       sel, we_rise, re_fall, mode_one, dir_target;
	logic       fifo_out_valid, fifo_pop;
	logic [7:0] fifo_out_data;

	logic [7:0] dq_q, dq_d;
	logic       dq_oe_q, dq_oe_d, dqs_q, dqs_d, dqs_oe_q, dqs_oe_d;
	logic       rb_oe_q, rb_oe_d, stby_q, stby_d;
	logic       cv_q, cv_d, pe_go_q, pe_go_d, pe_ref_q, pe_ref_d;
	ftpc_pkg::ftpc_cycle_s cyc_q, cyc_d;

	always_comb begin
		sel        = !pins_i.ce_n;
		mode_one   = (mode_i == ftpc_pkg::FTPC_DOUBLE_RATE_MODE_ONE);
		we_d       = {we_q[1:0], pins_i.write_strobe_n};
		re_d       = {re_q[1:0], pins_i.read_strobe_n};
		we_rise    = sel && we_q[1] && !we_q[2];
		re_fall    = sel && !mode_one && !re_q[1] && re_q[2];
		// Low on the shared pin means the host reads, so the target owns the bus.
		dir_target = sel && mode_one && !pins_i.read_strobe_n;
		fifo_pop   = re_fall && fifo_out_valid;

		cv_d  = 1'b0;
		cyc_d = cyc_q;
		if (we_rise && !mode_one) begin
			cyc_d.data = dq_i;
			if (pins_i.cle && !pins_i.ale) begin
				cyc_d.kind = ftpc_pkg::FTPC_KIND_CMD;
				cv_d       = 1'b1;
			end else if (pins_i.ale && !pins_i.cle) begin
				cyc_d.kind = ftpc_pkg::FTPC_KIND_ADDR;
				cv_d       = 1'b1;
			end else if (!pins_i.cle && !pins_i.ale &&
				mode_i == ftpc_pkg::FTPC_SINGLE_RATE_MODE) begin
				cyc_d.kind = ftpc_pkg::FTPC_KIND_DATA;
				cv_d       = 1'b1;
			end
		end

		dq_d     = fifo_pop ? fifo_out_data : dq_q;
		dq_oe_d  = mode_one ? dir_target : (sel && !re_q[1]);
		dqs_d    = re_q[1];
		dqs_oe_d = dir_target && (mode_i != ftpc_pkg::FTPC_SINGLE_RATE_MODE);
		rb_oe_d  = |unit_busy_i;
		stby_d   = pins_i.ce_n && !(|unit_busy_i);
		pe_go_d  = prog_erase_req_i && pins_i.write_protect_n;
		pe_ref_d = prog_erase_req_i && !pins_i.write_protect_n;
	end

	// ------------------------------------------------------------
	// Read data buffer
	// ------------------------------------------------------------
	// The array stalls whenever eight words wait for strobes.
	ftpc_fifo #(
		.WIDTH (ftpc_pkg::FTPC_DATA_W),
		.DEPTH (ftpc_pkg::FTPC_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i   (ref_clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (rd_valid_i),
		.in_ready_o  (rd_ready_o),
		.in_data_i   (rd_data_i),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_out_data)
	);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			we_q     <= ftpc_pkg::FTPC_SYNC_RST;
			re_q     <= ftpc_pkg::FTPC_SYNC_RST;
			dq_q     <= ftpc_pkg::FTPC_DATA_RST;
			dq_oe_q  <= 1'b0;
			dqs_q    <= 1'b0;
			dqs_oe_q <= 1'b0;
			rb_oe_q  <= 1'b0;
			stby_q   <= 1'b0;
			cv_q     <= 1'b0;
			cyc_q    <= '0;
			pe_go_q  <= 1'b0;
			pe_ref_q <= 1'b0;
		end else begin
			we_q     <= we_d;
			re_q     <= re_d;
			dq_q     <= dq_d;
			dq_oe_q  <= dq_oe_d;
			dqs_q    <= dqs_d;
			dqs_oe_q <= dqs_oe_d;
			rb_oe_q  <= rb_oe_d;
			stby_q   <= stby_d;
			cv_q     <= cv_d;
			cyc_q    <= cyc_d;
			pe_go_q  <= pe_go_d;
			pe_ref_q <= pe_ref_d;
		end
	end

	assign dq_o                 = dq_q;
	assign dq_oe_o              = dq_oe_q;
	assign dqs_o                = dqs_q;
	assign dqs_oe_o             = dqs_oe_q;
	assign ready_busy_n_o       = 1'b0;
	assign ready_busy_n_oe_o    = rb_oe_q;
	assign cycle_valid_o        = cv_q;
	assign cycle_o              = cyc_q;
	assign standby_o            = stby_q;
	assign prog_erase_go_o      = pe_go_q;
	assign prog_erase_refused_o = pe_ref_q;
endmodule : ftpc_target
